// >>> etm_pin_mux.sv
`timescale 1ns/1ns
module etm_pin_mux
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              clk_en_i,
  // strap pins, shared with host port data after reset
  input  wire logic              wide_host_port_strap_i,
  input  wire logic              watchdog_enable_strap_i,
  input  wire logic              host_port_sync_strap_i,
  input  wire logic [1:0]        clock_mode_straps_i,
  input  wire logic              config_source_strap_i,
  // configuration from on-chip registers
  input  wire logic              eth_on_bus_select_i,
  input  wire logic              mac_glue_enable_reg_i,
  input  wire logic [1:0]        mac_iface_mode_i,
  // strap values captured after reset release, once the synchroniser has filled
  output logic                   watchdog_enable_o,
  output logic                   host_port_sync_o,
  output logic [1:0]             clock_mode_o,
  output logic                   config_source_o,
  // pin role and routing result
  output logic                   straps_as_host_port_o,
  output etm_pkg::etm_route_t    route_o
);

  // ---------------------------------------------------------------------
  // strap synchronisation
  // ---------------------------------------------------------------------
  localparam int STRAP_W = $bits(etm_pkg::etm_strap_t);

  logic [STRAP_W-1:0] strap_sync;

  // the fill counter below is sized for the three stage synchroniser
  if (etm_pkg::SYNC_STAGES != 3)
  begin : g_stage_check
    $error("etm_pin_mux: SYNC_STAGES must be 3");
  end

  etm_sync #(.WIDTH(STRAP_W)) u_sync
  (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .async_i   ({wide_host_port_strap_i,
                 watchdog_enable_strap_i,
                 host_port_sync_strap_i,
                 clock_mode_straps_i,
                 config_source_strap_i}),
    .sync_o    (strap_sync)
  );

  // ---------------------------------------------------------------------
  // strap capture state
  // ---------------------------------------------------------------------
  // captured once, after the synchroniser has filled, then frozen
  typedef enum logic [1:0] {ST_FILL, ST_SETTLE, ST_CAPTURE, ST_RUN}
    etm_state_t;

  etm_state_t          state_r, state_nxt;
  etm_pkg::etm_strap_t strap_r, strap_nxt;
  logic [1:0]          fill_r, fill_nxt;
  logic                role_r, role_nxt;

  always_comb
  begin
    state_nxt = state_r;
    strap_nxt = strap_r;
    fill_nxt  = fill_r;
    unique case (state_r)
      ST_FILL:
      begin
        fill_nxt = fill_r + 2'h1;
        if (fill_r == 2'(etm_pkg::SYNC_STAGES - 1))
          state_nxt = ST_SETTLE;
      end
      ST_SETTLE:
        state_nxt = ST_CAPTURE;
      ST_CAPTURE:
      begin
        strap_nxt = etm_pkg::etm_strap_t'(strap_sync);
        state_nxt = ST_RUN;
      end
      ST_RUN: ;
    endcase
    role_nxt = (state_nxt == ST_RUN);
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_r <= ST_FILL;
      strap_r <= '0;
      fill_r  <= '0;
      role_r  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      state_r <= state_nxt;
      strap_r <= strap_nxt;
      fill_r  <= fill_nxt;
      role_r  <= role_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // captured strap outputs
  // ---------------------------------------------------------------------
  // pins switch to host port use only after capture
  assign straps_as_host_port_o = role_r;
  assign watchdog_enable_o     = strap_r.watchdog_enable_strap;
  assign host_port_sync_o      = strap_r.host_port_sync_strap;
  assign clock_mode_o          = strap_r.clock_mode_straps;
  assign config_source_o       = strap_r.config_source_strap;

  // ---------------------------------------------------------------------
  // routing decode
  // ---------------------------------------------------------------------
  etm_pkg::etm_sel_t   sel;
  etm_pkg::etm_route_t route_r, route_nxt;
  etm_pkg::etm_eth_kind_t kind;

  // only these four inputs steer routing
  always_comb
  begin
    sel.wide_host_port_strap = strap_r.wide_host_port_strap;
    sel.eth_on_bus_select    = eth_on_bus_select_i;
    sel.mac_glue_enable      = mac_glue_enable_reg_i;
    sel.mac_iface_mode       = mac_iface_mode_i;
  end

  // ---------------------------------------------------------------------
  // ethernet interface kind
  // ---------------------------------------------------------------------
  // mode 11 is undocumented; treated as if the glue were switched off
  always_comb
  begin
    unique case (sel.mac_iface_mode)
      etm_pkg::MODE_MII:  kind = etm_pkg::ETM_ETH_MII;
      etm_pkg::MODE_RMII: kind = etm_pkg::ETM_ETH_RMII;
      etm_pkg::MODE_SMII: kind = etm_pkg::ETM_ETH_SMII;
      default:            kind = etm_pkg::ETM_ETH_NONE;
    endcase
    if (!sel.mac_glue_enable)
      kind = etm_pkg::ETM_ETH_NONE;
  end

  // ---------------------------------------------------------------------
  // location, width and tdm decode
  // ---------------------------------------------------------------------
  always_comb
  begin
    route_nxt.host_port_wide = sel.wide_host_port_strap ?
      etm_pkg::WIDTH_64 : etm_pkg::WIDTH_32;
    route_nxt.sys_bus_wide = (!sel.wide_host_port_strap &&
      !sel.eth_on_bus_select) ? etm_pkg::WIDTH_64 : etm_pkg::WIDTH_32;
    route_nxt.tdm_avail   = etm_pkg::TDM_ALL;
    route_nxt.eth_on_bus  = etm_pkg::ETM_ETH_NONE;
    route_nxt.eth_on_gpio = etm_pkg::ETM_ETH_NONE;
    // at most one location chosen (none on the bus with the wide host port); the other stays empty
    if (!sel.eth_on_bus_select)
    begin
      route_nxt.eth_on_gpio = kind;
      if (kind == etm_pkg::ETM_ETH_MII)
        route_nxt.tdm_avail = etm_pkg::TDM_01;
      else if (kind != etm_pkg::ETM_ETH_NONE)
        route_nxt.tdm_avail = etm_pkg::TDM_013;
    end
    else if (!sel.wide_host_port_strap)
    begin
      // serial mii is not offered on the bus lanes
      if (kind != etm_pkg::ETM_ETH_SMII)
        route_nxt.eth_on_bus = kind;
    end
  end

  // ---------------------------------------------------------------------
  // route register
  // ---------------------------------------------------------------------
  etm_pkg::etm_route_t route_upd;

  // held empty until the strap is captured so no pin is driven twice
  always_comb
  begin
    route_upd = route_r;
    if (state_r == ST_RUN)
      route_upd = route_nxt;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      route_r <= '{tdm_avail: etm_pkg::TDM_ALL,
                   host_port_wide: etm_pkg::WIDTH_32,
                   sys_bus_wide: etm_pkg::WIDTH_64,
                   eth_on_bus: etm_pkg::ETM_ETH_NONE,
                   eth_on_gpio: etm_pkg::ETM_ETH_NONE};
    else if (clk_en_i)
      route_r <= route_upd;
  end

  assign route_o = route_r;

endmodule

// >>> etm_pkg.sv
package etm_pkg;

  // ---------------------------------------------------------------------
  // interface mode encodings
  // ---------------------------------------------------------------------
  localparam logic [1:0] MODE_MII  = 2'h0;
  localparam logic [1:0] MODE_SMII = 2'h1;
  localparam logic [1:0] MODE_RMII = 2'h2;

  // ---------------------------------------------------------------------
  // tdm availability masks, bit n = tdm port n
  // ---------------------------------------------------------------------
  localparam logic [3:0] TDM_ALL   = 4'hf;
  localparam logic [3:0] TDM_01    = 4'h3;
  localparam logic [3:0] TDM_013   = 4'hb;

  // ---------------------------------------------------------------------
  // bus width encodings and synchroniser depth
  // ---------------------------------------------------------------------
  localparam logic       WIDTH_32  = 1'b0;
  localparam logic       WIDTH_64  = 1'b1;
  localparam int         SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    ETM_ETH_NONE,
    ETM_ETH_MII,
    ETM_ETH_RMII,
    ETM_ETH_SMII
  } etm_eth_kind_t;

  typedef struct packed {
    logic       wide_host_port_strap;
    logic       watchdog_enable_strap;
    logic       host_port_sync_strap;
    logic [1:0] clock_mode_straps;
    logic       config_source_strap;
  } etm_strap_t;

  typedef struct packed {
    logic       wide_host_port_strap;
    logic       eth_on_bus_select;
    logic       mac_glue_enable;
    logic [1:0] mac_iface_mode;
  } etm_sel_t;

  typedef struct packed {
    logic [3:0]    tdm_avail;
    logic          host_port_wide;
    logic          sys_bus_wide;
    etm_eth_kind_t eth_on_bus;
    etm_eth_kind_t eth_on_gpio;
  } etm_route_t;

endpackage

// >>> etm_sync.sv
`timescale 1ns/1ns
module etm_sync
#(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             clk_en_i,
  // data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  if (WIDTH < 1)
  begin : g_width_check
    $error("etm_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] s1_r, s2_r, s3_r, out_r;
  logic [WIDTH-1:0] out_nxt;

  // a change counts only once the second and third stages agree
  always_comb
  begin
    out_nxt = out_r;
    for (int i = 0; i < WIDTH; i++)
      if (s2_r[i] == s3_r[i])
        out_nxt[i] = s3_r[i];
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end
    else if (clk_en_i)
    begin
      s1_r  <= async_i;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_o = out_r;

endmodule

// >>> etm_monitor.sv
`timescale 1ns/1ns
module etm_monitor
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                reset_n_i,
  input  wire logic                clk_en_i,
  // configuration
  input  wire logic                eth_on_bus_select_i,
  input  wire logic                mac_glue_enable_reg_i,
  input  wire logic [1:0]          mac_iface_mode_i,
  // results
  input  wire logic                watchdog_enable_o,
  input  wire logic [1:0]          clock_mode_o,
  input  wire logic                straps_as_host_port_o,
  input  wire etm_pkg::etm_route_t route_o
);
  logic       go_r;
  logic       loc_r;
  logic       en_r;
  logic [1:0] md_r;
  logic [7:0] pin;

  assign pin = {route_o.tdm_avail, route_o.eth_on_bus, route_o.eth_on_gpio};

  // ----
  // inputs seen at the edge that loaded route_o
  // ----
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      {go_r, loc_r, en_r, md_r} <= 5'h00;
    else
      {go_r, loc_r, en_r, md_r} <= {clk_en_i & straps_as_host_port_o,
        eth_on_bus_select_i, mac_glue_enable_reg_i, mac_iface_mode_i};
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_no_split: assert property (pin[3:2] == 2'h0 || pin[1:0] == 2'h0)
    else $error("ethernet split across both locations");
  chk_smii_bus: assert property (pin[3:2] != 2'h3)
    else $error("serial mii on bus lanes");
  chk_pre_role: assert property (!straps_as_host_port_o
    |-> route_o == 10'h3d0)
    else $error("route left reset value before capture");
  chk_strap_hold: assert property (straps_as_host_port_o
    && $past(straps_as_host_port_o)
    |-> $stable({watchdog_enable_o, clock_mode_o}))
    else $error("captured strap changed");
  chk_sys_width: assert property (go_r |->
    route_o.sys_bus_wide == (!loc_r && !route_o.host_port_wide))
    else $error("system bus width wrong");
  chk_glue_off: assert property (go_r && (!en_r || md_r == 2'h3)
    |-> pin == 8'hf0) else $error("ethernet shown while disabled");
  chk_mii_gpio: assert property (go_r && en_r && !loc_r && md_r == 2'h0
    |-> pin == 8'h31) else $error("mii on gpio wrong");
  chk_bus_mii: assert property (go_r && en_r && loc_r && md_r == 2'h0
    && !route_o.host_port_wide |-> pin == 8'hf4)
    else $error("mii on bus wrong");
  chk_wide_loc: assert property (go_r && loc_r && route_o.host_port_wide
    |-> pin == 8'hf0) else $error("ethernet shown with wide port");
endmodule

bind etm_pin_mux etm_monitor u_mon
(
  .clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
  .eth_on_bus_select_i(eth_on_bus_select_i),
  .mac_glue_enable_reg_i(mac_glue_enable_reg_i),
  .mac_iface_mode_i(mac_iface_mode_i), .watchdog_enable_o(watchdog_enable_o),
  .clock_mode_o(clock_mode_o), .straps_as_host_port_o(straps_as_host_port_o),
  .route_o(route_o)
);

// >>> tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED %0t mismatch", $time); end end
module tb_top;
  logic                clk_i     = 1'b0;
  logic                reset_n_i = 1'b0;
  logic                clk_en_i  = 1'b1;
  logic [5:0]          st        = 6'h00;
  logic [3:0]          cf        = 4'h0;
  logic                sw;
  logic                wd;
  logic                hs;
  logic                cs;
  logic                role;
  logic [1:0]          cm;
  etm_pkg::etm_route_t route;
  etm_pkg::etm_route_t e;
  int                  err_total = 0;
  int                  cmp_count = 0;
  int                  cyc       = 0;

  etm_pin_mux dut
  (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .wide_host_port_strap_i(st[5]), .watchdog_enable_strap_i(st[4]),
    .host_port_sync_strap_i(st[3]), .clock_mode_straps_i(st[2:1]),
    .config_source_strap_i(st[0]), .eth_on_bus_select_i(cf[3]),
    .mac_glue_enable_reg_i(cf[2]), .mac_iface_mode_i(cf[1:0]),
    .watchdog_enable_o(wd), .host_port_sync_o(hs), .clock_mode_o(cm),
    .config_source_o(cs), .straps_as_host_port_o(role), .route_o(route)
  );

  initial
    forever #25 clk_i = ~clk_i;

  task automatic end_sim();
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // run is about 170 cycles, so this only trips on a hang
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_total++;
      end_sim();
    end
  end

  // ----
  // table model: c = {location, enable, mode}
  // ----
  function automatic etm_pkg::etm_route_t exp_route(logic s, logic [3:0] c);
    etm_pkg::etm_route_t r;
    r = {4'hf, s, !s && !c[3], 4'h0};
    if (c[2] && !(s && c[3]) && c[1:0] != 2'h3)
    begin
      if (!c[3])
        r = {c[1] | c[0], 1'b0, 2'h3, s, !s, 2'h0, c[1] | c[0], !c[1]};
      else if (c[1:0] != 2'h1)
        r = {4'hf, s, 1'b0, c[1] ? 2'h2 : 2'h1, 2'h0};
    end
    return r;
  endfunction

  task automatic run_cfg(logic [3:0] c);
    cf = c;
    e = exp_route(sw, c);
    @(negedge clk_i);
    `CHK(route, e)
  endtask

  task automatic do_reset(logic [5:0] s);
    reset_n_i = 1'b0;
    st = s;
    sw = s[5];
    repeat (20) @(negedge clk_i);
    `CHK({role, wd, cm, route}, 14'h03d0)
    reset_n_i = 1'b1;
    repeat (7) @(negedge clk_i);
    `CHK({role, wd, hs, cm, cs}, {1'b1, s[4:0]})
    st = ~s;
  endtask

  initial
  begin
    void'($urandom(9581));
    for (int k = 0; k < 2; k++)
    begin
      do_reset({k[0], 5'($urandom)});
      for (int i = 0; i < 16; i++)
        run_cfg(i[3:0]);
      repeat (40) run_cfg(4'($urandom));
      // a stalled clock enable must hold the last route
      clk_en_i = 1'b0;
      cf = cf ^ 4'h4;
      @(negedge clk_i);
      `CHK(route, e)
      `CHK({wd, hs, cm, cs}, ~st[4:0])
      clk_en_i = 1'b1;
    end
    end_sim();
  end
endmodule
